// ===== ppp_core.v
// parallel programming port: pin decode, latches, arrays, busy timing
// assumes pins come asynchronously from the programmer, entry qualified
`timescale 1ns/1ps
`include "ppp_map.vh"
module ppp_core
(
  // clock and reset
  input  wire       clk,
  input  wire       rst,
  // programmer pins
  input  wire       prog_mode,
  input  wire       load_strobe,
  input  wire       load_action_sel0,
  input  wire       load_action_sel1,
  input  wire       page_latch_strobe,
  input  wire       write_n,
  input  wire       out_en_n,
  input  wire [7:0] data_in,
  // outputs
  output reg  [7:0] data_out,
  output reg        data_oe,
  output reg        prog_ready
);
  localparam ST_IDLE  = 2'd0;
  localparam ST_ERASE = 2'd1;
  localparam ST_WRITE = 2'd2;
  localparam [15:0] ERASE_CYC = `PPP_ERASE_CYC;
  localparam [15:0] WRITE_CYC = `PPP_WRITE_CYC;

  // two-flop synchronisers for all pins
  reg [14:0] s1_reg;
  reg [14:0] s2_reg;
  wire [14:0] pins = {prog_mode, load_strobe, load_action_sel0,
                      load_action_sel1, page_latch_strobe, write_n,
                      out_en_n, data_in};
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s1_reg <= 15'h0000;
      s2_reg <= 15'h0000;
    end
    else
    begin
      s1_reg <= pins;
      s2_reg <= s1_reg;
    end
  end
  wire       mode_s = s2_reg[14];                            // RQ14
  wire       xs_s   = s2_reg[13];
  wire       a0_s   = s2_reg[12];
  wire       a1_s   = s2_reg[11];
  wire       pl_s   = s2_reg[10];
  wire       wr_s   = s2_reg[9];
  wire       oe_s   = s2_reg[8];
  wire [7:0] d_s    = s2_reg[7:0];
  wire       bs_hi  = pl_s;
  wire       bs_ext = a1_s;

  reg xs_d_reg;
  reg pl_d_reg;
  reg wr_d_reg;
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      xs_d_reg <= 1'b0;
      pl_d_reg <= 1'b0;
      wr_d_reg <= 1'b1;
    end
    else
    begin
      xs_d_reg <= xs_s;
      pl_d_reg <= pl_s;
      wr_d_reg <= wr_s;
    end
  end
  wire xs_rise = mode_s & xs_s & ~xs_d_reg;
  wire pl_rise = mode_s & pl_s & ~pl_d_reg;
  wire wr_fall = mode_s & ~wr_s & wr_d_reg;

  // arrays
  reg [15:0] prog_mem [0:`PPP_PROG_WORDS-1];
  reg [7:0]  ee_mem   [0:`PPP_EE_BYTES-1];
  reg [15:0] page_buf [0:`PPP_PAGE_WORDS-1];

  reg [7:0]  cmd_reg;
  reg [15:0] addr_reg;
  reg [15:0] dat_reg;
  reg [7:0]  fuse_lo_reg;
  reg [7:0]  fuse_hi_reg;
  reg [7:0]  fuse_ext_reg;
  reg [7:0]  lock_reg;
  reg [1:0]  state_reg;
  reg [15:0] cnt_reg;
  reg [13:0] idx_reg;
  reg        keep_ee_reg;
  reg        pg_ee_reg;
  reg        page_dirty_reg;

  wire locked = (lock_reg[1:0] != 2'b11);
  wire [12:0] pg_base = {addr_reg[12:6], 6'd0};
  wire [8:0]  ee_base = {addr_reg[8:2], 2'd0};

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cmd_reg        <= `PPP_CMD_NOP;
      addr_reg       <= 16'h0000;
      dat_reg        <= 16'hFFFF;
      fuse_lo_reg    <= `PPP_FUSE_LO_RST;
      fuse_hi_reg    <= `PPP_FUSE_HI_RST;
      fuse_ext_reg   <= `PPP_FUSE_EXT_RST;
      lock_reg       <= `PPP_LOCK_RST;
      state_reg      <= ST_IDLE;
      cnt_reg        <= 16'h0000;
      idx_reg        <= 14'h0000;
      keep_ee_reg    <= 1'b0;
      pg_ee_reg      <= 1'b0;
      page_dirty_reg <= 1'b0;
      prog_ready     <= 1'b1;
    end
    else
    begin
      if (xs_rise && state_reg == ST_IDLE)                   // RQ26
      begin
        case ({a1_s, a0_s})                                  // RQ2
          `PPP_ACT_ADDR:
            if (bs_hi) addr_reg[15:8] <= d_s;                // RQ7
            else       addr_reg[7:0]  <= d_s;
          `PPP_ACT_DATA:
            if (bs_hi) dat_reg[15:8] <= d_s;
            else       dat_reg[7:0]  <= d_s;
          `PPP_ACT_CMD:
          begin
            cmd_reg <= d_s;                                  // RQ16
            if (d_s == `PPP_CMD_NOP)
              page_dirty_reg <= 1'b0;                        // RQ24
          end
          default: ;
        endcase
      end
      if (pl_rise && state_reg == ST_IDLE)                   // RQ9
      begin
        if (cmd_reg == `PPP_CMD_PROG_WR)
          page_buf[addr_reg[5:0]] <= dat_reg;
        else if (cmd_reg == `PPP_CMD_EE_WR)
          page_buf[{4'd0, addr_reg[1:0]}] <= {8'h00, dat_reg[7:0]};
        page_dirty_reg <= 1'b1;
      end
      case (state_reg)
        ST_IDLE:
          if (wr_fall)                                       // RQ3
          begin
            case (cmd_reg)
              `PPP_CMD_ERASE:                                // RQ4 RQ22
              begin
                state_reg   <= ST_ERASE;
                cnt_reg     <= ERASE_CYC;
                idx_reg     <= 14'h0000;
                keep_ee_reg <= ~fuse_hi_reg[`PPP_KEEP_EE_BIT]; // RQ20
                prog_ready  <= 1'b0;                         // RQ10
              end
              `PPP_CMD_FUSE_WR:                              // RQ4
              begin
                if (!locked)
                begin
                  if (bs_ext && !bs_hi) fuse_ext_reg <= dat_reg[7:0]; // RQ8
                  else if (bs_hi)       fuse_hi_reg  <= dat_reg[7:0];
                  else                  fuse_lo_reg  <= dat_reg[7:0];
                end
                state_reg  <= ST_WRITE;
                cnt_reg    <= WRITE_CYC;
                prog_ready <= 1'b0;
              end
              `PPP_CMD_LOCK_WR:
              begin
                lock_reg   <= lock_reg & dat_reg[7:0];
                state_reg  <= ST_WRITE;
                cnt_reg    <= WRITE_CYC;
                prog_ready <= 1'b0;
              end
              `PPP_CMD_PROG_WR, `PPP_CMD_EE_WR:              // RQ5 RQ23
                if (page_dirty_reg)
                begin
                  pg_ee_reg  <= (cmd_reg == `PPP_CMD_EE_WR);
                  idx_reg    <= 14'h0000;
                  state_reg  <= ST_WRITE;
                  cnt_reg    <= WRITE_CYC;
                  prog_ready <= 1'b0;
                end
              default: ;
            endcase
          end
        ST_ERASE:                                            // RQ19
        begin
          if (idx_reg < `PPP_PROG_WORDS)
          begin
            prog_mem[idx_reg[12:0]] <= 16'hFFFF;
            if (!keep_ee_reg && idx_reg < `PPP_EE_BYTES)
              ee_mem[idx_reg[8:0]] <= `PPP_ERASED;
            idx_reg <= idx_reg + 14'd1;
          end
          else
            lock_reg <= `PPP_LOCK_RST;
          // saturate: erase sweep outlasts the timer, no wrap
          if (cnt_reg != 16'h0000)
            cnt_reg <= cnt_reg - 16'd1;
          if (cnt_reg <= 16'd1 && idx_reg >= `PPP_PROG_WORDS)
          begin
            state_reg  <= ST_IDLE;
            prog_ready <= 1'b1;                              // RQ10
          end
        end
        ST_WRITE:
        begin
          if (page_dirty_reg && !locked
              && (cmd_reg == `PPP_CMD_PROG_WR || cmd_reg == `PPP_CMD_EE_WR))
          begin
            if (!pg_ee_reg && idx_reg < `PPP_PAGE_WORDS)
              prog_mem[pg_base | {7'd0, idx_reg[5:0]}]
                <= page_buf[idx_reg[5:0]];
            else if (pg_ee_reg && idx_reg < `PPP_EE_PAGE)
              ee_mem[ee_base | {7'd0, idx_reg[1:0]}]
                <= page_buf[idx_reg[5:0]][7:0];
          end
          idx_reg <= idx_reg + 14'd1;
          cnt_reg <= cnt_reg - 16'd1;
          if (cnt_reg <= 16'd1)
          begin
            state_reg  <= ST_IDLE;
            prog_ready <= 1'b1;                              // RQ23
          end
        end
        default:
          state_reg <= ST_IDLE;
      endcase
    end
  end

  // read path
  reg [7:0]  rd_next;
  reg [15:0] pw;
  always @*
  begin
    pw      = prog_mem[addr_reg[12:0]];
    rd_next = `PPP_ERASED;
    case (cmd_reg)                                           // RQ6
      `PPP_CMD_SIG_RD:  rd_next = 8'h00;
      `PPP_CMD_FL_RD:                                        // RQ25
        case ({bs_ext, bs_hi})
          2'b00:   rd_next = fuse_lo_reg;
          2'b11:   rd_next = fuse_hi_reg;
          2'b10:   rd_next = fuse_ext_reg;
          default: rd_next = lock_reg;
        endcase
      `PPP_CMD_PROG_RD:
        if (lock_reg[1:0] == 2'b00) rd_next = `PPP_ERASED;
        else rd_next = bs_hi ? pw[15:8] : pw[7:0];           // RQ7
      `PPP_CMD_EE_RD:
        if (lock_reg[1:0] == 2'b00) rd_next = `PPP_ERASED;
        else rd_next = ee_mem[addr_reg[8:0]];
      default: rd_next = `PPP_ERASED;
    endcase
  end

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      data_out <= 8'h00;
      data_oe  <= 1'b0;
    end
    else
    begin
      data_oe  <= mode_s & ~oe_s;                            // RQ11
      data_out <= rd_next;
    end
  end
endmodule // ppp_core

// ===== ppp_map.vh
// constants for the parallel programming port: commands, codes, timing
// assumes a 100 MHz core clock sampling all programmer pins
// Function
// RQ1: programmer strobes last at least 250 ns each.
// RQ2: load strobe rise acts on action bits: address, data, command, idle.
// RQ3: write or output-enable strobe runs the last loaded command.
// RQ4: commands 0x80 chip erase, 0x40 fuse write, 0x20 lock write.
// RQ5: commands 0x10 program page write, 0x11 eeprom page write.
// RQ6: commands 0x08 signature, 0x04 fuse/lock, 0x02 program, 0x03 eeprom read.
// RQ7: byte_select_hi chooses low or high byte.
// RQ8: byte_select_ext chooses low or extended high byte.
// RQ9: page latch pulse moves loaded data into the page buffer.
// RQ10: prog_ready low while erasing or programming, high otherwise.
// RQ11: data bus driven only while output enable is low.
// RQ12: programmer holds reset low and toggles load strobe six times.
// RQ13: entry pins zero at least 100 ns before high voltage.
// RQ14: entry pins must stay stable 100 ns after high voltage.
// RQ15: programmer waits 50 us after high voltage before a command.
// RQ16: command and address latches persist across operations.
// RQ17: programmer reloads address high byte only for a new window.
// RQ18: erased cells read 0xFF; programmer may skip writing them.
// RQ19: chip erase clears program, eeprom and lock, keeps fuses.
// RQ20: keep-eeprom fuse programmed makes erase spare the eeprom.
// RQ21: programmer erases before reprogramming memories.
// RQ22: write strobe after erase command starts erase, ready drops.
// RQ23: write strobe after page load programs page, ready low until done.
// RQ24: command 0x00 ends page programming and resets write signals.
// RQ25: fuse/lock read selects byte by select pair; zero means programmed.
// RQ26: pin values sampled on load strobe rise into the selected latch.
`ifndef PPP_MAP_VH
`define PPP_MAP_VH
`define PPP_CMD_ERASE      8'h80
`define PPP_CMD_FUSE_WR    8'h40
`define PPP_CMD_LOCK_WR    8'h20
`define PPP_CMD_PROG_WR    8'h10
`define PPP_CMD_EE_WR      8'h11
`define PPP_CMD_SIG_RD     8'h08
`define PPP_CMD_FL_RD      8'h04
`define PPP_CMD_PROG_RD    8'h02
`define PPP_CMD_EE_RD      8'h03
`define PPP_CMD_NOP        8'h00
`define PPP_ACT_ADDR       2'b00
`define PPP_ACT_DATA       2'b01
`define PPP_ACT_CMD        2'b10
`define PPP_ERASED         8'hFF
`define PPP_FUSE_LO_RST    8'h62
`define PPP_FUSE_HI_RST    8'hDF
`define PPP_FUSE_EXT_RST   8'hFF
`define PPP_LOCK_RST       8'hFF
`define PPP_KEEP_EE_BIT    3
`define PPP_PROG_WORDS     8192
`define PPP_EE_BYTES       512
`define PPP_PAGE_WORDS     64
`define PPP_EE_PAGE        4
`define PPP_ERASE_NS       9000
`define PPP_WRITE_NS       4500
`define PPP_CLK_NS         10
`define PPP_ERASE_CYC      ((`PPP_ERASE_NS + `PPP_CLK_NS - 1) / `PPP_CLK_NS)
`define PPP_WRITE_CYC      ((`PPP_WRITE_NS + `PPP_CLK_NS - 1) / `PPP_CLK_NS)
`endif

// ===== ppp_core_checker.sv
// checker for the programming port core
// bound to ppp_core, sees only its ports
`timescale 1ns/1ps
module ppp_core_checker
(
  // clock and reset
  input wire logic       clk,
  input wire logic       rst,
  // programmer pins
  input wire logic       prog_mode,
  input wire logic       load_strobe,
  input wire logic       load_action_sel0,
  input wire logic       load_action_sel1,
  input wire logic       page_latch_strobe,
  input wire logic       write_n,
  input wire logic       out_en_n,
  input wire logic [7:0] data_in,
  // outputs
  input wire logic [7:0] data_out,
  input wire logic       data_oe,
  input wire logic       prog_ready
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic [13:0] busy_cnt_reg;
  always_ff @(posedge clk or posedge rst)
    if (rst || prog_ready)
      busy_cnt_reg <= 14'h0000;
    else
      busy_cnt_reg <= busy_cnt_reg + 14'h0001;
  sequence s_oe_on;
    (!out_en_n && prog_mode)[*6];
  endsequence
  sequence s_wr_seen;
    !$past(write_n, 3) && $past(prog_mode, 4);
  endsequence
  sequence s_quiet;
    ($stable({load_strobe, page_latch_strobe, load_action_sel1, data_in})
      && !out_en_n && write_n && prog_ready)[*8];
  endsequence
  AST_OE_ON: assert property (s_oe_on |-> data_oe)
    else $error("bus not driven during output enable");
  AST_OE_OFF: assert property (out_en_n[*6] |-> !data_oe)
    else $error("bus driven without output enable");
  AST_BUSY_CAUSE: assert property ($fell(prog_ready) |-> s_wr_seen)
    else $error("busy without write strobe");
  AST_BUSY_MIN: assert property ($fell(prog_ready) |-> !prog_ready[*8])
    else $error("busy too short");
  AST_BUSY_LEN: assert property ($rose(prog_ready) |->
    busy_cnt_reg inside {[14'h01c1:14'h01c3], [14'h2000:14'h2002]})
    else $error("busy length off");
  AST_BUSY_BOUND: assert property (busy_cnt_reg <= 14'h2002)
    else $error("busy never ends");
  AST_DOUT_HOLD: assert property (s_quiet |-> $stable(data_out))
    else $error("read data moved with steady pins");
  AST_RESET_VAL: assert property ($fell(rst) |-> prog_ready && !data_oe)
    else $error("wrong state after reset");
endmodule // ppp_core_checker
bind ppp_core ppp_core_checker chk_u
(
  .clk(clk), .rst(rst), .prog_mode(prog_mode), .load_strobe(load_strobe),
  .load_action_sel0(load_action_sel0), .load_action_sel1(load_action_sel1),
  .page_latch_strobe(page_latch_strobe), .write_n(write_n),
  .out_en_n(out_en_n), .data_in(data_in), .data_out(data_out),
  .data_oe(data_oe), .prog_ready(prog_ready)
);

// ===== ppp_prog_model.sv
// programmer model: drives the port pins, waits on ready
// assumes clk is the core clock; pins move at falling edges, except the 62.5 ns entry toggles of load strobe
`timescale 1ns/1ps
module ppp_prog_model
(
  // clock and device side
  input  wire logic       clk,
  input  wire logic       prog_ready,
  input  wire logic [7:0] bus,
  // programmer pins
  output logic            prog_mode,
  output logic            load_strobe,
  output logic            load_action_sel0,
  output logic            load_action_sel1,
  output logic            page_latch_strobe,
  output logic            write_n,
  output logic            out_en_n,
  output logic [7:0]      data
);
  localparam int PW = 30;
  initial
  begin
    {prog_mode, load_strobe, page_latch_strobe} = 3'h0;
    {load_action_sel1, load_action_sel0, write_n, out_en_n} = 4'hf;
    data = 8'h00;
  end
  task automatic hold(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic enter();
    #1;
    repeat (12) #62.5 load_strobe = ~load_strobe;
    @(negedge clk);
    {page_latch_strobe, load_action_sel1, load_action_sel0} = 3'h0;
    write_n = 1'b0;
    hold(15);
    prog_mode = 1'b1;
    hold(15);
    write_n = 1'b1;
    hold(5000);
  endtask
  task automatic load(input logic [1:0] act, input logic hi,
                      input logic [7:0] v);
    {load_action_sel1, load_action_sel0} = act;
    page_latch_strobe = hi;
    data = v;
    hold(PW);
    load_strobe = 1'b1;
    hold(PW);
    load_strobe = 1'b0;
  endtask
  task automatic latch();
    page_latch_strobe = 1'b0;
    hold(PW);
    page_latch_strobe = 1'b1;
    hold(PW);
    page_latch_strobe = 1'b0;
  endtask
  task automatic pulse_wr(input logic ext, hi, output bit ok);
    {load_action_sel1, page_latch_strobe} = {ext, hi};
    write_n = 1'b0;
    hold(PW);
    write_n = 1'b1;
    ok = 1'b0;
    for (int i = 0; i < 9000 && !ok; i++)
      @(negedge clk) ok = (prog_ready === 1'b1);
  endtask
  task automatic rd(input logic ext, hi, output logic [7:0] v);
    {load_action_sel1, page_latch_strobe} = {ext, hi};
    out_en_n = 1'b0;
    hold(PW);
    v = bus;
    out_en_n = 1'b1;
    hold(PW);
  endtask
endmodule // ppp_prog_model

// ===== tb_top.sv
// testbench: core, programmer model and reference arrays
// assumes ppp_core and ppp_map.vh compiled alongside
`timescale 1ns/1ps
`include "ppp_map.vh"
module tb_top;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        prog_mode, load_strobe, load_action_sel0, load_action_sel1;
  logic        page_latch_strobe, write_n, out_en_n, data_oe, prog_ready;
  logic [7:0]  pdata, data_out;
  wire  [7:0]  bus = data_oe ? data_out : (out_en_n ? pdata : ~pdata);
  int          n_errors = 0;
  int          n_tests = 0;
  logic [15:0] rnd = 16'h8e62;
  logic [15:0] flash_m[int];
  logic [7:0]  ee_m[int];
  logic [7:0]  fz[4];
  always #5 clk = ~clk;
  ppp_core dut_u (.clk(clk), .rst(rst), .prog_mode(prog_mode),
    .load_strobe(load_strobe), .load_action_sel0(load_action_sel0),
    .load_action_sel1(load_action_sel1), .write_n(write_n),
    .page_latch_strobe(page_latch_strobe), .out_en_n(out_en_n),
    .data_in(bus), .data_out(data_out), .data_oe(data_oe),
    .prog_ready(prog_ready));
  ppp_prog_model prog_u (.clk(clk), .prog_ready(prog_ready), .bus(bus),
    .prog_mode(prog_mode), .load_strobe(load_strobe),
    .load_action_sel0(load_action_sel0), .data(pdata),
    .load_action_sel1(load_action_sel1), .write_n(write_n),
    .page_latch_strobe(page_latch_strobe), .out_en_n(out_en_n));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic report_and_stop();
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic check(input string nm, input logic [7:0] seen, exp);
    n_tests++;
    if (seen !== exp || $isunknown(exp))
    begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cmd(input logic [7:0] c);
    prog_u.load(2'h2, 1'b0, c);
  endtask
  task automatic wr(input logic ext, hi);
    bit ok;
    prog_u.pulse_wr(ext, hi, ok);
    if (!ok)
    begin
      n_errors++;
      report_and_stop();
    end
  endtask
  task automatic check_all();
    logic [7:0] v;
    logic       lk;
    lk = (fz[1][1:0] == 2'h0);
    cmd(`PPP_CMD_FL_RD);
    for (int i = 0; i < 4; i++)
    begin
      prog_u.rd(i[1], i[0], v);
      check("fuse", v, fz[i]);
    end
    cmd(`PPP_CMD_PROG_RD);
    prog_u.load(2'h0, 1'b1, 8'h01);
    for (int w = 0; w < 2; w++)
    begin
      prog_u.load(2'h0, 1'b0, w[7:0]);
      prog_u.rd(1'b0, 1'b0, v);
      check("flash lo", v, lk ? 8'hff : flash_m[256 + w][7:0]);
      prog_u.rd(1'b0, 1'b1, v);
      check("flash hi", v, lk ? 8'hff : flash_m[256 + w][15:8]);
    end
    cmd(`PPP_CMD_EE_RD);
    prog_u.load(2'h0, 1'b1, 8'h00);
    for (int w = 0; w < 2; w++)
    begin
      prog_u.load(2'h0, 1'b0, 8'h10 + w[7:0]);
      prog_u.rd(1'b0, 1'b0, v);
      check("eeprom", v, lk ? 8'hff : ee_m[16 + w]);
    end
  endtask
  initial
  begin
    repeat (95000) @(posedge clk);
    n_errors++;
    report_and_stop();
  end
  initial
  begin
    logic [7:0] v;
    fz = '{`PPP_FUSE_LO_RST, `PPP_LOCK_RST, `PPP_FUSE_EXT_RST,
           `PPP_FUSE_HI_RST};
    repeat (8) @(negedge clk);
    rst = 1'b0;
    check("ready", {7'h00, prog_ready}, 8'h01);
    prog_u.enter();
    cmd(`PPP_CMD_ERASE);
    wr(1'b0, 1'b0);
    for (int w = 0; w < 2; w++)
    begin
      flash_m[256 + w] = 16'hffff;
      ee_m[16 + w] = `PPP_ERASED;
    end
    cmd(`PPP_CMD_FUSE_WR);
    for (int i = 0; i < 3; i++)
    begin
      rnd = lfsr(rnd);
      v = (i == 1) ? 8'hf7 : rnd[7:0];
      prog_u.load(2'h1, 1'b0, v);
      wr(i[1], i == 1);
      fz[i == 0 ? 0 : 4 - i] = v;
    end
    check_all();
    $display("test fuses done");
    cmd(`PPP_CMD_PROG_WR);
    for (int w = 0; w < 2; w++)
    begin
      rnd = lfsr(rnd);
      flash_m[256 + w] = rnd;
      prog_u.load(2'h0, 1'b0, w[7:0]);
      prog_u.load(2'h1, 1'b0, rnd[7:0]);
      prog_u.load(2'h1, 1'b1, rnd[15:8]);
      prog_u.latch();
    end
    prog_u.load(2'h0, 1'b1, 8'h01);
    wr(1'b0, 1'b0);
    cmd(`PPP_CMD_NOP);
    cmd(`PPP_CMD_EE_WR);
    prog_u.load(2'h0, 1'b1, 8'h00);
    for (int w = 0; w < 2; w++)
    begin
      rnd = lfsr(rnd);
      ee_m[16 + w] = rnd[7:0];
      prog_u.load(2'h0, 1'b0, 8'h10 + w[7:0]);
      prog_u.load(2'h1, 1'b0, rnd[7:0]);
      prog_u.latch();
    end
    wr(1'b0, 1'b0);
    cmd(`PPP_CMD_NOP);
    check_all();
    $display("test page writes done");
    cmd(`PPP_CMD_LOCK_WR);
    prog_u.load(2'h1, 1'b0, 8'hfc);
    wr(1'b0, 1'b0);
    fz[1] = fz[1] & 8'hfc;
    check_all();
    cmd(`PPP_CMD_SIG_RD);
    prog_u.load(2'h0, 1'b0, 8'h00);
    prog_u.load(2'h3, 1'b0, `PPP_CMD_PROG_RD);
    prog_u.rd(1'b0, 1'b0, v);
    check("signature", v, 8'h00);
    cmd(`PPP_CMD_ERASE);
    wr(1'b0, 1'b0);
    foreach (flash_m[k])
      flash_m[k] = 16'hffff;
    fz[1] = `PPP_LOCK_RST;
    check_all();
    $display("test lock and erase done");
    report_and_stop();
  end
endmodule // tb_top
